/* verilog/piw_pkg.sv */
// Shared constants and types of the inbound window translate stage.
package piw_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] PIW_WIN0_LOW_OFS  = 12'h018; // Window 0 base, low word.
  localparam logic [11:0] PIW_WIN0_HIGH_OFS = 12'h01C; // Window 0 base, high word.
  localparam logic [11:0] PIW_WIN1_LOW_OFS  = 12'h020; // Window 1 base, low word.
  localparam logic [11:0] PIW_WIN1_HIGH_OFS = 12'h024; // Window 1 base, high word.
  localparam logic [11:0] PIW_SIZE_CFG_OFS  = 12'h04C; // Enables, sizes, translate.
  localparam logic [11:0] PIW_LUT_FIRST_OFS = 12'h500; // First lookup entry.
  localparam logic [11:0] PIW_LUT_LAST_OFS  = 12'h6FC; // Last lookup entry.

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int PIW_IO_BIT     = 0;  // I/O-mode flag in a base low word.
  localparam int PIW_TYPE_LSB   = 1;  // Two-bit memory type field.
  localparam int PIW_PREF_BIT   = 3;  // Prefetchable flag.
  localparam int PIW_BASE_LSB   = 15; // Lowest compared base bit.
  localparam int PIW_CFG_STRIDE = 8;  // Bits per window in the size config.
  localparam int PIW_EN_BIT     = 0;  // Window enable within a stride.
  localparam int PIW_TOFF_BIT   = 1;  // Translate-off within a stride.
  localparam int PIW_SIZE_LSB   = 2;  // Five-bit size code within a stride.
  localparam int PIW_DEST_LSB   = 0;  // Destination field in a low entry.
  localparam int PIW_PADDR_LSB  = 10; // Page address bits in a low entry.

  // ----------------------------------------
  // Geometry and reset values
  // ----------------------------------------
  localparam int          PIW_NWIN      = 2;          // Number of windows.
  localparam int          PIW_PAGE_BITS = 5;          // 32 pages per window.
  localparam logic [5:0]  PIW_PAGE_SH   = 6'd10;      // Smallest page is 1 Kbyte.
  localparam logic [63:0] PIW_PAGE_MIN  = 64'h400;    // Smallest page size.
  localparam logic [3:0]  PIW_DEST_HLP  = 4'h0;       // Host local peripheral port.
  localparam logic [31:0] PIW_REG_RST   = 32'h0;      // Reset of the window and size registers.
  localparam logic [31:0] PIW_LOW_MASK  = 32'hFFFF_800F; // Writable low-base bits.

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid; // Access requested.
    logic        write; // One for write, zero for read.
    logic [11:0] addr;  // Byte offset in the register block.
    logic [31:0] wdata; // Write data.
  } piw_reg_req_t;

  typedef struct packed {
    logic        valid; // One-cycle decision pulse.
    logic        claim; // Request hit an enabled window.
    logic [3:0]  dest;  // Destination port.
    logic [63:0] addr;  // Fabric address.
  } piw_fab_t;

endpackage

/* verilog/piw_lut_mem.sv */
// Page lookup memory: 64 entries of a low and a high word each.
module piw_lut_mem
  import piw_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  input  wire logic        ce,
  // Write port, one half per strobe.
  input  wire logic        we_low,
  input  wire logic        we_high,
  input  wire logic [5:0]  waddr,
  input  wire logic [31:0] wdata,
  // Read port, data registered.
  input  wire logic [5:0]  raddr,
  output logic      [63:0] rdata
);

  // Storage; high word in the upper half.
  logic [63:0] mem [64];

  // Writes and the registered read.
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (we_low)
        mem[waddr][31:0] <= wdata;
      if (we_high)
        mem[waddr][63:32] <= wdata;
      rdata <= mem[raddr];
    end
  end

endmodule

/* verilog/piw_win_decode.sv */
// Window hit check and page split of one inbound window.
module piw_win_decode
  import piw_pkg::*;
(
  // Window setup.
  input  wire logic        en,
  input  wire logic [4:0]  size,
  input  wire logic [63:0] base,
  // Incoming address.
  input  wire logic [63:0] addr,
  // Decode results.
  output logic             hit,
  output logic      [4:0]  page,
  output logic      [63:0] off_mask
);

  // Page shift and masks derived from the size code.
  wire logic [5:0]  page_sh  = PIW_PAGE_SH + {1'b0, size};
  wire logic [63:0] win_mask = {off_mask[63-PIW_PAGE_BITS:0], {PIW_PAGE_BITS{1'b1}}};
  wire logic [63:0] shifted  = addr >> page_sh;

  // Offset keeps the low page bits; the page index sits just above.
  assign off_mask = (PIW_PAGE_MIN << size) - 64'h1;
  assign page     = shifted[PIW_PAGE_BITS-1:0];
  // Bits above the window are compared only while enabled.
  assign hit = en && (((addr ^ base) & ~win_mask) == 64'h0);

endmodule

/* verilog/piw_top.sv */
// Inbound address windows, page lookup and translation toward the fabric.
//
// Overview of operation
// - Claim requests inside enabled windows, forward them.
// - Two 64-bit windows at 0x018/0x01C, 0x020/0x024.
// - Size config enables and sizes; disabled never decodes.
// - Each window splits into 32 equal pages.
// - Low entry always; high entry only translating.
// - Lookup entries fill offsets 0x500 through 0x6FC.
// - Registers writable from PCI or processor path.
// - Size code zero: 32K window, 1K pages.
// - 32K: compare 63:15, page 14:10, offset 9:0.
// - Destination from low entry; zero is host port.
// - Translated address: page address plus offset.
// - Host port gets low 32 address bits.
// - Low base holds prefetch, type, I/O flags.
module piw_top
  import piw_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Register path through the PCI register window.
  input  wire piw_reg_req_t pci_reg,
  output logic              pci_reg_ready,
  // Register path through the processor register window.
  input  wire piw_reg_req_t cpu_reg,
  output logic              cpu_reg_ready,
  // Read answers, shared by both paths.
  output logic              reg_rvalid,
  output logic      [31:0]  reg_rdata,
  // Initiator request.
  input  wire logic         req_valid,
  input  wire logic [63:0]  req_addr,
  output logic              req_ready,
  // Decision toward the fabric.
  output piw_fab_t          fab
);

  // ----------------------------------------
  // Register path selection
  // ----------------------------------------

  // The PCI path wins when both ask in one cycle.
  wire piw_reg_req_t rq      = pci_reg.valid ? pci_reg : cpu_reg;
  wire logic         rq_any  = ce && (pci_reg.valid || cpu_reg.valid);
  wire logic         rq_wr   = rq_any && rq.write;
  wire logic         rq_rd   = rq_any && !rq.write;
  wire logic         rq_lut  = (rq.addr >= PIW_LUT_FIRST_OFS) && (rq.addr <= PIW_LUT_LAST_OFS);
  wire logic [11:0]  lut_ofs = rq.addr - PIW_LUT_FIRST_OFS;
  // Word index: bit 6 window, bit 5 high half, bits 4:0 page.
  wire logic [6:0]   lut_idx = lut_ofs[8:2];
  wire logic         lut_rd  = rq_rd && rq_lut;

  // A lookup read borrows the memory port, so it holds off a request.
  assign pci_reg_ready = ce;
  assign cpu_reg_ready = ce && !pci_reg.valid;
  assign req_ready     = ce && !lut_rd;

  // ----------------------------------------
  // Window and size registers
  // ----------------------------------------

  logic [31:0] base_low_reg  [PIW_NWIN]; // Base low words with flags.
  logic [31:0] base_high_reg [PIW_NWIN]; // Base high words.
  logic [31:0] size_cfg_reg;             // Enables, translate-off, sizes.

  // Decoded setup and decode results per window.
  logic [63:0] win_base [PIW_NWIN];
  logic        win_en   [PIW_NWIN];
  logic        win_toff [PIW_NWIN];
  logic [4:0]  win_size [PIW_NWIN];
  logic        win_hit  [PIW_NWIN];
  logic [4:0]  win_page [PIW_NWIN];
  logic [63:0] win_mask [PIW_NWIN];

  // Per-window registers, fields and decoder.
  genvar w;
  generate
    for (w = 0; w < PIW_NWIN; w++)
    begin : g_win
      localparam logic [11:0] LOW_OFS  = w ? PIW_WIN1_LOW_OFS : PIW_WIN0_LOW_OFS;
      localparam logic [11:0] HIGH_OFS = w ? PIW_WIN1_HIGH_OFS : PIW_WIN0_HIGH_OFS;
      localparam int          CFG      = w * PIW_CFG_STRIDE;

      // Base registers take writes from either path.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          base_low_reg[w]  <= PIW_REG_RST;
          base_high_reg[w] <= PIW_REG_RST;
        end
        else if (rq_wr && rq.addr == LOW_OFS)
          base_low_reg[w] <= rq.wdata & PIW_LOW_MASK;
        else if (rq_wr && rq.addr == HIGH_OFS)
          base_high_reg[w] <= rq.wdata;
      end

      // Compared base: high word above the low base bits.
      assign win_base[w] = {base_high_reg[w], base_low_reg[w][31:PIW_BASE_LSB],
                            {PIW_BASE_LSB{1'b0}}};
      assign win_en[w]   = size_cfg_reg[CFG+PIW_EN_BIT];
      assign win_toff[w] = size_cfg_reg[CFG+PIW_TOFF_BIT];
      assign win_size[w] = size_cfg_reg[CFG+PIW_SIZE_LSB +: 5];

      // Hit test and page split; size zero gives 1K pages.
      piw_win_decode u_dec (
        .en       (win_en[w]),
        .size     (win_size[w]),
        .base     (win_base[w]),
        .addr     (req_addr),
        .hit      (win_hit[w]),
        .page     (win_page[w]),
        .off_mask (win_mask[w])
      );
    end
  endgenerate

  // Size configuration register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      size_cfg_reg <= PIW_REG_RST;
    else if (rq_wr && rq.addr == PIW_SIZE_CFG_OFS)
      size_cfg_reg <= rq.wdata;
  end

  // ----------------------------------------
  // Request decode and lookup read
  // ----------------------------------------

  wire logic       take   = req_valid && req_ready;
  // Window 0 wins when both windows overlap.
  wire logic       hit_w1 = !win_hit[0] && win_hit[1];
  wire logic       any_hit = win_hit[0] || win_hit[1];
  wire logic [4:0] page    = hit_w1 ? win_page[1] : win_page[0];
  wire logic [5:0] mem_ra  = lut_rd ? {lut_idx[6], lut_idx[4:0]} : {hit_w1, page};

  // Lookup memory writes from either path.
  wire logic       lut_we  = rq_wr && rq_lut;
  logic [63:0]     mem_q;

  piw_lut_mem u_lut (
    .clk     (clk),
    .ce      (ce),
    .we_low  (lut_we && !lut_idx[5]),
    .we_high (lut_we && lut_idx[5]),
    .waddr   ({lut_idx[6], lut_idx[4:0]}),
    .wdata   (rq.wdata),
    .raddr   (mem_ra),
    .rdata   (mem_q)
  );

  // Read data of the non-lookup registers; unmapped offsets read zero.
  wire logic [31:0] plain_rd =
    (rq.addr == PIW_WIN0_LOW_OFS)  ? base_low_reg[0]  :
    (rq.addr == PIW_WIN0_HIGH_OFS) ? base_high_reg[0] :
    (rq.addr == PIW_WIN1_LOW_OFS)  ? base_low_reg[1]  :
    (rq.addr == PIW_WIN1_HIGH_OFS) ? base_high_reg[1] :
    (rq.addr == PIW_SIZE_CFG_OFS)  ? size_cfg_reg     : 32'h0;

  // ----------------------------------------
  // First stage: held while the lookup is read
  // ----------------------------------------

  logic        p_req_reg;   // A request was taken.
  logic        p_hit_reg;   // It hit a window.
  logic        p_toff_reg;  // That window has translation off.
  logic [63:0] p_addr_reg;  // Incoming address.
  logic [63:0] p_mask_reg;  // In-page offset mask.
  logic        p_rd_reg;    // A register read is pending.
  logic        p_lut_reg;   // It reads the lookup memory.
  logic        p_half_reg;  // It reads the high half.
  logic [31:0] p_rdat_reg;  // Plain register read data.

  // Capture the request and register read at the taking edge.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      p_req_reg  <= 1'b0;
      p_hit_reg  <= 1'b0;
      p_toff_reg <= 1'b0;
      p_addr_reg <= 64'h0;
      p_mask_reg <= 64'h0;
      p_rd_reg   <= 1'b0;
      p_lut_reg  <= 1'b0;
      p_half_reg <= 1'b0;
      p_rdat_reg <= 32'h0;
    end
    else if (ce)
    begin
      p_req_reg  <= take;
      p_hit_reg  <= any_hit;
      p_toff_reg <= hit_w1 ? win_toff[1] : win_toff[0];
      p_addr_reg <= req_addr;
      p_mask_reg <= hit_w1 ? win_mask[1] : win_mask[0];
      p_rd_reg   <= rq_rd;
      p_lut_reg  <= rq_lut;
      p_half_reg <= lut_idx[5];
      p_rdat_reg <= plain_rd;
    end
  end

  // ----------------------------------------
  // Translation
  // ----------------------------------------

  wire logic [3:0]  dest   = mem_q[PIW_DEST_LSB +: 4];
  // Page address: high entry above, low entry bits 31:10 below.
  wire logic [63:0] page_a = {mem_q[63:32], mem_q[31:PIW_PADDR_LSB],
                              {PIW_PADDR_LSB{1'b0}}};
  // Offset stays as it came; the page address supplies the rest.
  wire logic [63:0] xlate  = (page_a & ~p_mask_reg) | (p_addr_reg & p_mask_reg);
  // Translation off forwards the address unchanged.
  wire logic [63:0] out_a  = p_toff_reg ? p_addr_reg : xlate;
  wire logic        to_hlp = (dest == PIW_DEST_HLP);
  wire logic [63:0] fab_a  = to_hlp ? {32'h0, out_a[31:0]} : out_a;

  // Decision and read answer, one cycle after the first stage.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fab        <= '0;
      reg_rvalid <= 1'b0;
      reg_rdata  <= 32'h0;
    end
    else if (ce)
    begin
      fab.valid  <= p_req_reg;
      reg_rvalid <= p_rd_reg;
      // Decision fields change only with a decision, so they hold between pulses.
      if (p_req_reg)
      begin
        fab.claim <= p_hit_reg;
        fab.dest  <= p_hit_reg ? dest : 4'h0;
        fab.addr  <= p_hit_reg ? fab_a : 64'h0;
      end
      // Read data change only with an answer; idle cycles hold the last answer.
      if (p_rd_reg)
        reg_rdata <= !p_lut_reg ? p_rdat_reg :
                     p_half_reg ? mem_q[63:32] : mem_q[31:0];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A take produces a decision two edges later.
  decide_lat_a: assert property (take ##1 ce |=> fab.valid)
    else $error("No decision two cycles after a take.");

  // A hit is claimed.
  hit_claim_a: assert property (take && any_hit ##1 ce |=> fab.claim)
    else $error("Hit not claimed.");

  // A request with both windows disabled is refused.
  off_noclaim_a: assert property ((take && !win_en[0] && !win_en[1]) ##1 ce
                                  |=> fab.valid && !fab.claim)
    else $error("Disabled window decoded.");

  // A miss is never claimed and carries no address.
  miss_clean_a: assert property (fab.valid && !fab.claim |-> fab.addr == 64'h0)
    else $error("Unclaimed decision carries an address.");

  // Host port decisions keep only 32 address bits.
  hlp_trunc_a: assert property (fab.claim && fab.dest == PIW_DEST_HLP
                                |-> fab.addr[63:32] == 32'h0)
    else $error("Host port address not truncated.");

  // A 32K window keeps address bits 9:0 as the offset.
  offset_keep_a: assert property ((take && win_hit[0] && win_size[0] == 5'h0) ##1 ce
                                  |=> fab.addr[9:0] == $past(req_addr[9:0], 2))
    else $error("Page offset not preserved.");

  // A size configuration write lands on the next edge.
  cfg_write_a: assert property (rq_wr && rq.addr == PIW_SIZE_CFG_OFS
                                |=> size_cfg_reg == $past(rq.wdata))
    else $error("Size configuration write lost.");

  // A lookup read stalls requests and answers two edges later.
  lut_read_a: assert property (lut_rd |-> !req_ready ##1 ce ##1 reg_rvalid)
    else $error("Lookup read not answered.");

  // Translation off in window 0 passes the low address bits through.
  toff_pass_a: assert property ((take && win_hit[0] && win_toff[0]) ##1 ce
                                |=> fab.addr[31:0] == $past(req_addr[31:0], 2))
    else $error("Untranslated address changed.");

  // A base low write keeps only base and flag bits.
  low_mask_a: assert property (rq_wr && rq.addr == PIW_WIN0_LOW_OFS
                               |=> base_low_reg[0] == ($past(rq.wdata) & PIW_LOW_MASK))
    else $error("Base low write not masked.");

  // A size configuration read answers with the value held at the taking edge.
  cfg_read_a: assert property ((rq_rd && rq.addr == PIW_SIZE_CFG_OFS) ##1 ce
                               |=> reg_rvalid && reg_rdata == $past(size_cfg_reg, 2))
    else $error("Size configuration read wrong.");

endmodule

/* test/piw_init_model.sv */
// Initiator and fabric side model: issues requests and collects decisions.
module piw_init_model
  import piw_pkg::*;
(
  // Clock.
  clk,
  // Request toward the stage.
  req_valid,
  req_addr,
  req_ready,
  // Decision from the stage.
  fab
);
  timeunit 1ns;
  timeprecision 100ps;
  input  wire logic        clk;       // Bus clock.
  output logic             req_valid; // Request present.
  output logic      [63:0] req_addr;  // Request address.
  input  wire logic        req_ready; // Stage takes the request.
  input  wire piw_fab_t    fab;       // Decision toward the fabric.

  // Idle lines start low.
  initial
  begin
    req_valid = 1'b0;
    req_addr  = 64'h0;
  end

  // Holds a request until taken, then waits a bounded time for its decision.
  // A released address shows its inverse so that a stale value is never reused.
  task automatic send(input logic [63:0] a, output piw_fab_t got, output logic ok);
    int n;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_addr  = a;
    do @(posedge clk); while (req_ready !== 1'b1);
    #1;
    req_valid = 1'b0;
    req_addr  = ~a;
    n = 0;
    while (fab.valid !== 1'b1 && n < 4)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    got = fab;
    ok  = (n == 1); // Set at the first edge after the take, sampled high just after that edge.
  endtask
endmodule

/* test/pci_inbound_window_translate_tb_top.sv */
// Self-checking bench for the inbound window translate stage.
module pci_inbound_window_translate_tb_top
  import piw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic         clk;           // 100 MHz clock.
  logic         rst;           // Active high reset.
  logic         ce;            // Run enable, held high.
  piw_reg_req_t pci_reg;       // PCI register path.
  piw_reg_req_t cpu_reg;       // Processor register path.
  logic         pci_reg_ready; // PCI path ready.
  logic         cpu_reg_ready; // Processor path ready.
  logic         reg_rvalid;    // Read answer pulse.
  logic  [31:0] reg_rdata;     // Read answer data.
  logic         req_valid;     // Initiator request.
  logic  [63:0] req_addr;      // Initiator address.
  logic         req_ready;     // Request taken.
  piw_fab_t     fab;           // Fabric decision.
  int           error_cnt;     // Mismatches.
  int           cmp_count;     // Comparisons.
  logic  [11:0] rst_ofs [5];   // Offsets checked after reset.
  logic  [31:0] rd_q;          // Read data of a direct access.

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  piw_top dut (.clk(clk), .rst(rst), .ce(ce), .pci_reg(pci_reg),
    .pci_reg_ready(pci_reg_ready), .cpu_reg(cpu_reg), .cpu_reg_ready(cpu_reg_ready),
    .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_addr(req_addr), .req_ready(req_ready), .fab(fab));
  piw_init_model u_ini (.clk(clk), .req_valid(req_valid), .req_addr(req_addr),
    .req_ready(req_ready), .fab(fab));

  // Clock generator.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compares a value with its expectation and counts the result.
  task automatic chk(input logic [68:0] got, input logic [68:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One register access on either path; reads wait a bounded time for the answer.
  task automatic reg_acc(input logic cpu, input logic wr, input logic [11:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    #1;
    if (cpu)
      cpu_reg = '{1'b1, wr, a, d};
    else
      pci_reg = '{1'b1, wr, a, d};
    do @(posedge clk); while ((cpu ? cpu_reg_ready : pci_reg_ready) !== 1'b1);
    #1;
    pci_reg = '0;
    cpu_reg = '0;
    q = 32'h0;
    n = 0;
    while (!wr && reg_rvalid !== 1'b1 && n < 5)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!wr)
      q = reg_rdata;
    if (n == 5)
      chk(69'h0, 69'h1); // A missing answer counts as a mismatch.
  endtask

  // Register write on the chosen path.
  task automatic wr(input logic cpu, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    reg_acc(cpu, 1'b1, a, d, q);
  endtask

  // Register read through the PCI path with a compare.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    reg_acc(1'b0, 1'b0, a, 32'h0, q);
    chk({37'h0, q}, {37'h0, exp});
  endtask

  // One initiator request with a compare of claim, destination and address.
  task automatic req(input logic [63:0] a, input logic [68:0] exp);
    piw_fab_t f;
    logic     ok;
    u_ini.send(a, f, ok);
    chk({f.claim, f.dest, f.addr}, exp);
    if (!ok)
      chk(69'h0, 69'h1); // Wrong decision latency.
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog against a hang.
  initial
  begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    error_cnt = 0;
    cmp_count = 0;
    rst = 1'b1;
    ce = 1'b1;
    pci_reg = '0;
    cpu_reg = '0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    // Window and size registers come out of reset cleared.
    rst_ofs = '{PIW_WIN0_LOW_OFS, PIW_WIN0_HIGH_OFS, PIW_WIN1_LOW_OFS,
                PIW_WIN1_HIGH_OFS, PIW_SIZE_CFG_OFS};
    foreach (rst_ofs[i])
      rd(rst_ofs[i], PIW_REG_RST);
    $display("test reset_values done");
    // Base low keeps only flag and base bits; unmapped place reads zero.
    wr(1'b0, 12'h018, 32'hFFFF_FFFF);
    rd(12'h018, 32'hFFFF_800F);
    wr(1'b0, 12'h01C, 32'hA5A5_5A5A);
    rd(12'h01C, 32'hA5A5_5A5A);
    wr(1'b0, 12'h030, 32'h1234_5678);
    rd(12'h030, 32'h0000_0000);
    $display("test register_fields done");
    // Window 1 at 0xC0000000, prefetchable type 2, but not yet enabled.
    wr(1'b0, 12'h020, 32'hC000_000C);
    wr(1'b0, 12'h024, 32'h0000_0000);
    rd(12'h020, 32'hC000_000C);
    req(64'hC000_2340, 69'h0);
    $display("test disabled_window done");
    // 32K window, page 8 to the host port, page 9 to port 2 with a high part.
    wr(1'b0, 12'h04C, 32'h0000_0100);
    wr(1'b0, 12'h620, 32'hE900_0000);
    wr(1'b0, 12'h6A0, 32'h1234_5678);
    wr(1'b0, 12'h624, 32'hA000_0402);
    wr(1'b0, 12'h6A4, 32'h0000_0008);
    wr(1'b0, 12'h6FC, 32'h5A5A_A5A5);
    rd(12'h620, 32'hE900_0000);
    rd(12'h6FC, 32'h5A5A_A5A5);
    // The processor path reads the same lookup entry.
    reg_acc(1'b1, 1'b0, 12'h620, 32'h0, rd_q);
    chk({37'h0, rd_q}, {37'h0, 32'hE900_0000});
    req(64'hC000_2340, {1'b1, 4'h0, 64'h0000_0000_E900_0340});
    req(64'hC000_2555, {1'b1, 4'h2, 64'h0000_0008_A000_0555});
    req(64'hC000_8000, 69'h0);
    req(64'h1_C000_2340, 69'h0);
    $display("test translate done");
    // Window 0 set up from the processor path with translation off.
    wr(1'b1, 12'h018, 32'h7000_000C);
    wr(1'b1, 12'h01C, 32'h0000_0000);
    wr(1'b1, 12'h500, 32'h5000_0003);
    wr(1'b1, 12'h04C, 32'h0000_0103);
    rd(12'h04C, 32'h0000_0103);
    req(64'h7000_0010, {1'b1, 4'h3, 64'h0000_0000_7000_0010});
    req(64'hC000_2555, {1'b1, 4'h2, 64'h0000_0008_A000_0555});
    $display("test cpu_path done");
    give_verdict();
  end
endmodule
